// >>> owg_cfg.svh
`ifndef OWG_CFG_SVH
`define OWG_CFG_SVH

// ------------------------------------------------------------
// Device register map (reached over the device APB port)
// ------------------------------------------------------------
`define OWG_DEV_DISP_OFS 32'h0000_0010
`define OWG_DEV_STRIDE_OFS 32'h0000_0054
`define OWG_DEV_XPOS_OFS 32'h0000_0058
`define OWG_DEV_YPOS_OFS 32'h0000_005C
`define OWG_DEV_RST_VAL 32'h0000_0000

// ------------------------------------------------------------
// Device field layout
// ------------------------------------------------------------
`define OWG_FIELD_W 10
`define OWG_END_LSB 16
`define OWG_START_LSB 0
`define OWG_STRIDE_LSB 0
`define OWG_DISP_EN_BIT 19
`define OWG_DISP_ROT_LSB 16
`define OWG_DISP_BPP_LSB 0
`define OWG_DISP_BPP_W 5

// ------------------------------------------------------------
// Controller register map (software APB slave)
// ------------------------------------------------------------
`define OWG_REG_CTRL 12'h000
`define OWG_REG_STATUS 12'h004
`define OWG_REG_XCOORD 12'h008
`define OWG_REG_YCOORD 12'h00C
`define OWG_REG_PANEL 12'h010
`define OWG_REG_RST_VAL 32'h0000_0000
`define OWG_CTRL_GO_BIT 0
`define OWG_CTRL_EN_BIT 1
`define OWG_ST_BUSY_BIT 0
`define OWG_ST_DONE_BIT 1
`define OWG_ST_ALIGN_BIT 2
`define OWG_ST_BPP_BIT 3

`endif

// >>> owg_pkg.sv
package owg_pkg;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        OWG_IDLE = 7'b000_0001,
        OWG_RD_DISP = 7'b000_0010,
        OWG_CALC = 7'b000_0100,
        OWG_WR_STRIDE = 7'b000_1000,
        OWG_WR_XPOS = 7'b001_0000,
        OWG_WR_YPOS = 7'b010_0000,
        OWG_WR_DISP = 7'b100_0000
    } owg_state_t;

    // Rotation codes as held in the display settings register
    typedef enum logic [1:0] {
        OWG_ROT0 = 2'b00,
        OWG_ROT90 = 2'b01,
        OWG_ROT180 = 2'b10,
        OWG_ROT270 = 2'b11
    } owg_rot_t;

    // One request towards the device bus
    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic [31:0] wdata;
    } owg_req_t;

endpackage

// >>> owg_geom.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// One position field: optional mirror, optional dword scaling
// ------------------------------------------------------------
module owg_geom #(
    parameter int W = 10
) (
    // Operands
    input wire logic [W-1:0] coord,
    input wire logic [W-1:0] extent,
    input wire logic mirror,
    input wire logic scale,
    input wire logic [2:0] shift,
    // Result
    output logic [W-1:0] field
);
    logic [W-1:0] val;

    if (W < 2 || W > 16) begin : g_chk
        $error("owg_geom: W out of range");
    end

    // Mirrored edges count from the far panel side; fraction is dropped by the shift
    always_comb begin
        val = mirror ? W'(extent - coord - W'(1)) : coord;
        field = scale ? (val >> shift) : val;
    end
endmodule

// >>> owg_apb_master.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// APB master towards the device registers
// ------------------------------------------------------------
module owg_apb_master
    import owg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request side
    input wire logic start,
    input owg_req_t req,
    output logic done,
    output logic [31:0] rdata,
    // Device bus
    output logic m_psel,
    output logic m_penable,
    output logic m_pwrite,
    output logic [31:0] m_paddr,
    output logic [31:0] m_pwdata,
    input wire logic [31:0] m_prdata,
    input wire logic m_pready
);
    // Setup, then access held until the slave answers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_psel <= 1'b0;
            m_penable <= 1'b0;
            m_pwrite <= 1'b0;
            m_paddr <= 32'h0000_0000;
            m_pwdata <= 32'h0000_0000;
        end else if (start && !m_psel) begin
            m_psel <= 1'b1;
            m_paddr <= req.addr;
            m_pwrite <= req.write;
            m_pwdata <= req.wdata;
        end else if (m_psel && !m_penable) begin
            m_penable <= 1'b1;
        end else if (m_psel && m_pready) begin
            m_psel <= 1'b0;
            m_penable <= 1'b0;
        end
    end

    // Read data is taken only at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            done <= m_psel && m_penable && m_pready;
            if (m_psel && m_penable && m_pready) begin
                rdata <= m_prdata;
            end
        end
    end

    apb_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (m_psel && m_penable && !m_pready) |=> (m_psel && m_penable && $stable(m_paddr) && $stable(m_pwdata)))
        else $error("device request changed before completion");
endmodule

// >>> owg_ctrl.sv
`timescale 1ns/10ps
`include "owg_cfg.svh"
module owg_ctrl
    import owg_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Software APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device APB master
    output logic m_psel,
    output logic m_penable,
    output logic m_pwrite,
    output logic [31:0] m_paddr,
    output logic [31:0] m_pwdata,
    input wire logic [31:0] m_prdata,
    input wire logic m_pready
);
    localparam int FW = `OWG_FIELD_W;

    owg_state_t state_r;
    owg_req_t req_r;
    logic start_r, en_r, go_r, m_done;
    logic done_r, align_err_r, bpp_err_r;
    logic [31:0] m_rdata, disp_r, xpos_r, ypos_r, xpos_c, ypos_c;
    logic [FW-1:0] xl, xr, yt, yb, pw, ph, stride_r, stride_c, span, lowmask;
    logic [FW-1:0] xe_c, xs_c, ye_c, ys_c;
    logic [2:0] shift_r, shift_c;
    logic bpp_ok, swap, mir_x, mir_y, misaligned;
    logic wr_acc, setup, ev_done, ev_align, ev_bpp;
    owg_rot_t rot_r;

    // ------------------------------------------------------------
    // Software register slave
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;

    // Zero wait state: ready in the first access cycle, read data fixed in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `OWG_REG_RST_VAL;
        end else begin
            pready <= setup;
            pslverr <= 1'b0;
            if (setup) begin
                prdata <= `OWG_REG_RST_VAL;
                unique case (paddr)
                    `OWG_REG_CTRL: prdata[`OWG_CTRL_EN_BIT] <= en_r;
                    `OWG_REG_STATUS: prdata <= {28'h000_0000, bpp_err_r, align_err_r, done_r, state_r != OWG_IDLE};
                    `OWG_REG_XCOORD: prdata <= {6'h00, xr, 6'h00, xl};
                    `OWG_REG_YCOORD: prdata <= {6'h00, yb, 6'h00, yt};
                    `OWG_REG_PANEL: prdata <= {6'h00, ph, 6'h00, pw};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Coordinates and enable; a go while busy is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            go_r <= 1'b0;
            {xr, xl, yb, yt, ph, pw} <= '0;
        end else begin
            go_r <= wr_acc && paddr == `OWG_REG_CTRL && pwdata[`OWG_CTRL_GO_BIT] && state_r == OWG_IDLE;
            if (wr_acc) begin
                unique case (paddr)
                    `OWG_REG_CTRL: en_r <= pwdata[`OWG_CTRL_EN_BIT];
                    `OWG_REG_XCOORD: {xr, xl} <= {pwdata[`OWG_END_LSB +: FW], pwdata[`OWG_START_LSB +: FW]};
                    `OWG_REG_YCOORD: {yb, yt} <= {pwdata[`OWG_END_LSB +: FW], pwdata[`OWG_START_LSB +: FW]};
                    `OWG_REG_PANEL: {ph, pw} <= {pwdata[`OWG_END_LSB +: FW], pwdata[`OWG_START_LSB +: FW]};
                    default: ;
                endcase
            end
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
            align_err_r <= 1'b0;
            bpp_err_r <= 1'b0;
        end else begin
            if (wr_acc && paddr == `OWG_REG_STATUS) begin
                if (pwdata[`OWG_ST_DONE_BIT]) done_r <= 1'b0;
                if (pwdata[`OWG_ST_ALIGN_BIT]) align_err_r <= 1'b0;
                if (pwdata[`OWG_ST_BPP_BIT]) bpp_err_r <= 1'b0;
            end
            if (ev_done) done_r <= 1'b1;
            if (ev_align) align_err_r <= 1'b1;
            if (ev_bpp) bpp_err_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Geometry of the device fields
    // ------------------------------------------------------------
    // Colour depth decode: shift is log2 of the pixel step per dword
    always_comb begin
        bpp_ok = 1'b1;
        unique case (m_rdata[`OWG_DISP_BPP_LSB +: `OWG_DISP_BPP_W])
            5'h01: shift_c = 3'd5;
            5'h02: shift_c = 3'd4;
            5'h04: shift_c = 3'd3;
            5'h08: shift_c = 3'd2;
            5'h10: shift_c = 3'd1;
            default: begin
                shift_c = 3'd0;
                bpp_ok = 1'b0;
            end
        endcase
    end

    assign swap = rot_r[0];
    assign mir_x = rot_r[1];
    assign mir_y = rot_r[0] ^ rot_r[1];

    // X end is the right edge, scaled, at 0 degrees; bottom line at 90
    // mirrored left edge at 180; mirrored top line at 270
    owg_geom #(.W(FW)) u_xend (
        .coord(swap ? (mir_x ? yt : yb) : (mir_x ? xl : xr)),
        .extent(pw),
        .mirror(mir_x),
        .scale(!swap),
        .shift(shift_r),
        .field(xe_c)
    );
    // X start uses the same step as X end
    owg_geom #(.W(FW)) u_xstart (
        .coord(swap ? (mir_x ? yb : yt) : (mir_x ? xr : xl)),
        .extent(pw),
        .mirror(mir_x),
        .scale(!swap),
        .shift(shift_r),
        .field(xs_c)
    );
    // Y fields take the other axis against the panel height
    owg_geom #(.W(FW)) u_yend (
        .coord(swap ? (mir_y ? xl : xr) : (mir_y ? yt : yb)),
        .extent(ph),
        .mirror(mir_y),
        .scale(swap),
        .shift(shift_r),
        .field(ye_c)
    );
    owg_geom #(.W(FW)) u_ystart (
        .coord(swap ? (mir_y ? xr : xl) : (mir_y ? yb : yt)),
        .extent(ph),
        .mirror(mir_y),
        .scale(swap),
        .shift(shift_r),
        .field(ys_c)
    );

    always_comb begin
        xpos_c = `OWG_DEV_RST_VAL;
        ypos_c = `OWG_DEV_RST_VAL;
        xpos_c[`OWG_END_LSB +: FW] = xe_c;
        xpos_c[`OWG_START_LSB +: FW] = xs_c;
        ypos_c[`OWG_END_LSB +: FW] = ye_c;
        ypos_c[`OWG_START_LSB +: FW] = ys_c;
    end

    // dword stride; from X fields, from Y fields
    assign stride_c = swap ? FW'(ye_c - ys_c + FW'(1)) : FW'(xe_c - xs_c + FW'(1));

    // span along the fetched axis must fill whole dwords
    assign span = swap ? FW'(yb - yt + FW'(1)) : FW'(xr - xl + FW'(1));
    assign lowmask = ~({FW{1'b1}} << shift_r);
    assign misaligned = |(span & lowmask);

    // ------------------------------------------------------------
    // Programming sequencer
    // ------------------------------------------------------------
    assign ev_bpp = state_r == OWG_RD_DISP && m_done && !bpp_ok;
    assign ev_align = state_r == OWG_CALC && misaligned;
    assign ev_done = state_r == OWG_WR_DISP && m_done;

    // Read settings first: the overlay must follow the main window's depth and rotation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= OWG_IDLE;
            start_r <= 1'b0;
            req_r <= '0;
            disp_r <= `OWG_DEV_RST_VAL;
            rot_r <= OWG_ROT0;
            shift_r <= 3'd0;
            xpos_r <= `OWG_DEV_RST_VAL;
            ypos_r <= `OWG_DEV_RST_VAL;
            stride_r <= '0;
        end else begin
            start_r <= 1'b0;
            unique case (state_r)
                OWG_IDLE: if (go_r) begin
                    state_r <= OWG_RD_DISP;
                    start_r <= 1'b1;
                    req_r <= '{addr: `OWG_DEV_DISP_OFS, write: 1'b0, wdata: `OWG_DEV_RST_VAL};
                end
                OWG_RD_DISP: if (m_done) begin
                    disp_r <= m_rdata;
                    rot_r <= owg_rot_t'(m_rdata[`OWG_DISP_ROT_LSB +: 2]);
                    shift_r <= shift_c;
                    state_r <= bpp_ok ? OWG_CALC : OWG_IDLE;
                end
                OWG_CALC: begin
                    // shifted fields already drop the fraction
                    xpos_r <= xpos_c;
                    ypos_r <= ypos_c;
                    stride_r <= stride_c;
                    // misaligned width is refused, nothing written
                    if (misaligned) begin
                        state_r <= OWG_IDLE;
                    end else begin
                        state_r <= OWG_WR_STRIDE;
                        start_r <= 1'b1;
                        req_r <= '{addr: `OWG_DEV_STRIDE_OFS, write: 1'b1, wdata: {22'h00_0000, stride_c}};
                    end
                end
                OWG_WR_STRIDE: if (m_done) begin
                    state_r <= OWG_WR_XPOS;
                    start_r <= 1'b1;
                    req_r <= '{addr: `OWG_DEV_XPOS_OFS, write: 1'b1, wdata: xpos_r};
                end
                OWG_WR_XPOS: if (m_done) begin
                    state_r <= OWG_WR_YPOS;
                    start_r <= 1'b1;
                    req_r <= '{addr: `OWG_DEV_YPOS_OFS, write: 1'b1, wdata: ypos_r};
                end
                OWG_WR_YPOS: if (m_done) begin
                    state_r <= OWG_WR_DISP;
                    start_r <= 1'b1;
                    // only the enable bit changes; depth and rotation kept
                    req_r <= '{addr: `OWG_DEV_DISP_OFS, write: 1'b1,
                        wdata: {disp_r[31:20], en_r, disp_r[18:0]}};
                end
                OWG_WR_DISP: if (m_done) begin
                    state_r <= OWG_IDLE;
                end
                default: state_r <= OWG_IDLE;
            endcase
        end
    end

    owg_apb_master u_master (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_r),
        .req(req_r),
        .done(m_done),
        .rdata(m_rdata),
        .m_psel(m_psel),
        .m_penable(m_penable),
        .m_pwrite(m_pwrite),
        .m_paddr(m_paddr),
        .m_pwdata(m_pwdata),
        .m_prdata(m_prdata),
        .m_pready(m_pready)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    stride_fmt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (start_r && req_r.addr == `OWG_DEV_STRIDE_OFS) |-> (req_r.wdata[31:10] == 22'h00_0000))
        else $error("stride write has bits above the count");
    stride_val_a: assert property (@(posedge pclk) disable iff (!presetn)
        (start_r && req_r.addr == `OWG_DEV_STRIDE_OFS) |-> ##2 (req_r.wdata[9:0] == (swap
        ? FW'(ypos_r[25:16] - ypos_r[9:0] + FW'(1)) : FW'(xpos_r[25:16] - xpos_r[9:0] + FW'(1)))))
        else $error("stride does not match position span");
    xpos_fmt_a: assert property (@(posedge pclk) disable iff (!presetn)
        (start_r && req_r.addr == `OWG_DEV_XPOS_OFS) |-> (req_r.wdata[31:26] == 6'h00 && req_r.wdata[15:10] == 6'h00))
        else $error("unused X position bits set");
    align_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == OWG_CALC && misaligned) |=> (state_r == OWG_IDLE && align_err_r && !start_r))
        else $error("misaligned window not refused");
    rot0_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == OWG_CALC && rot_r == OWG_ROT0) |=> (xpos_r[25:16] == ($past(xr) >> $past(shift_r))))
        else $error("X end wrong at 0 degrees");
    rot90_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == OWG_CALC && rot_r == OWG_ROT90) |=> (xpos_r[25:16] == $past(yb)))
        else $error("X end wrong at 90 degrees");
    rot180_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == OWG_CALC && rot_r == OWG_ROT180)
        |=> (xpos_r[25:16] == (FW'($past(pw) - $past(xl) - FW'(1)) >> $past(shift_r))))
        else $error("X end wrong at 180 degrees");
    rot270_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_r == OWG_CALC && rot_r == OWG_ROT270) |=> (xpos_r[25:16] == FW'($past(pw) - $past(yt) - FW'(1))))
        else $error("X end wrong at 270 degrees");
    disp_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        (start_r && req_r.write && req_r.addr == `OWG_DEV_DISP_OFS)
        |-> (req_r.wdata[19] == en_r && req_r.wdata[17:16] == rot_r))
        else $error("display settings write alters more than the enable");
endmodule

// >>> owg_dev_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Device register model behind the controller's master port
// ------------------------------------------------------------
module owg_dev_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus from the controller
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    // Test hooks: answer delay, display settings preload
    input wire logic [1:0] slow,
    input wire logic disp_load,
    input wire logic [31:0] disp_val
);
    logic [31:0] disp_r, stride_r, xpos_r, ypos_r, rd;
    logic [1:0] wait_r;
    // Ready after the chosen number of wait cycles
    assign pready = psel && penable && (wait_r == slow);
    // Read mux; unmapped places read zero
    always_comb begin
        case (paddr)
            32'h0000_0010: rd = disp_r;
            32'h0000_0054: rd = stride_r;
            32'h0000_0058: rd = xpos_r;
            32'h0000_005C: rd = ypos_r;
            default: rd = 32'h0000_0000;
        endcase
    end
    // Lines toggle outside an answer so stale data never looks valid
    assign prdata = pready ? rd : ~rd;
    // Wait counter runs only inside a stalled access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 2'b00;
        end else begin
            wait_r <= (psel && penable && !pready) ? wait_r + 2'b01 : 2'b00;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_r <= 32'h0000_0000;
            stride_r <= 32'h0000_0000;
            xpos_r <= 32'h0000_0000;
            ypos_r <= 32'h0000_0000;
        end else if (disp_load) begin
            disp_r <= disp_val;
        end else if (pready && pwrite) begin
            if (paddr == 32'h0000_0010) disp_r <= pwdata;
            if (paddr == 32'h0000_0054) stride_r <= pwdata & 32'h0000_03FF;
            if (paddr == 32'h0000_0058) xpos_r <= pwdata & 32'h03FF_03FF;
            if (paddr == 32'h0000_005C) ypos_r <= pwdata & 32'h03FF_03FF;
        end
    end
endmodule

// >>> tb.sv
`timescale 1ns/10ps
module tb;
    // ------------------------------------------------------------
    // Geometry used by every run: spans of 64 align for all depths
    // ------------------------------------------------------------
    localparam logic [9:0] PW = 10'h140;
    localparam logic [9:0] PH = 10'h0F0;
    localparam logic [9:0] XL = 10'h020;
    localparam logic [9:0] XR = 10'h05F;
    localparam logic [9:0] YT = 10'h000;
    localparam logic [9:0] YB = 10'h03F;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, m_paddr, m_pwdata, m_prdata;
    logic pready, pslverr, m_psel, m_penable, m_pwrite, m_pready;
    logic [1:0] slow = 2'b00;
    logic disp_load = 1'b0;
    logic [31:0] disp_val = 32'h0000_0000;
    int n_fail = 0;
    int samples_checked = 0;
    // Free-running 40 MHz clock
    always #12.5 pclk = ~pclk;
    owg_ctrl i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
        .m_pwdata(m_pwdata), .m_prdata(m_prdata), .m_pready(m_pready));
    owg_dev_model i_dev (.pclk(pclk), .presetn(presetn), .psel(m_psel), .penable(m_penable),
        .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .prdata(m_prdata), .pready(m_pready),
        .slow(slow), .disp_load(disp_load), .disp_val(disp_val));
    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic wrap_up();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One edge first, so a release and a new setup never share a step
    // Answer is taken only at the edge that sees pready high; the watchdog ends a hang
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        chk(nm, exp, r);
    endtask
    // Preload device settings, program the window, start and await a flag
    task automatic run(input logic [1:0] rot, input logic [4:0] bpp, input logic [9:0] xr);
        logic [31:0] r;
        logic e;
        @(posedge pclk);
        disp_load <= 1'b1;
        disp_val <= {14'h0000, rot, 11'h000, bpp};
        @(posedge pclk);
        disp_load <= 1'b0;
        wr(12'h008, {6'h00, xr, 6'h00, XL});
        wr(12'h00C, {6'h00, YB, 6'h00, YT});
        wr(12'h010, {6'h00, PH, 6'h00, PW});
        wr(12'h004, 32'h0000_000E);
        wr(12'h000, 32'h0000_0003);
        r = 32'h0000_0000;
        while (r[3:1] === 3'b000) begin
            apb(12'h004, 1'b0, 32'h0000_0000, r, e);
        end
    endtask
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, st0;
        logic e;
        logic [9:0] xe, xs, ye, ys, sd;
        logic [1:0] rot;
        int s;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rc(12'h004, 32'h0000_0000, "status");
        rc(12'h008, 32'h0000_0000, "xcoord");
        chk("dev stride", 32'h0000_0000, i_dev.stride_r);
        // Unmapped place: error flagged, write dropped, reads zero
        apb(12'h014, 1'b1, 32'hFFFF_FFFF, r, e);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        apb(12'h014, 1'b0, 32'h0000_0000, r, e);
        chk("unmapped rd", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, r);
        // Every rotation with every colour depth
        for (int q = 0; q < 4; q++) begin
            for (int b = 0; b < 5; b++) begin
                rot = q[1:0];
                s = 5 - b;
                slow <= rot;
                xe = rot == 0 ? XR >> s : rot == 1 ? YB : rot == 2 ? (PW - XL - 1) >> s : PW - YT - 1;
                xs = rot == 0 ? XL >> s : rot == 1 ? YT : rot == 2 ? (PW - XR - 1) >> s : PW - YB - 1;
                ye = rot == 0 ? YB : rot == 1 ? (PH - XL - 1) >> s : rot == 2 ? PH - YT - 1 : XR >> s;
                ys = rot == 0 ? YT : rot == 1 ? (PH - XR - 1) >> s : rot == 2 ? PH - YB - 1 : XL >> s;
                sd = rot[0] ? ye - ys + 10'h001 : xe - xs + 10'h001;
                run(rot, 5'(1 << b), XR);
                rc(12'h004, 32'h0000_0002, "status done");
                chk("dev stride", {22'h0, sd}, i_dev.stride_r);
                chk("dev xpos", {6'h00, xe, 6'h00, xs}, i_dev.xpos_r);
                chk("dev ypos", {6'h00, ye, 6'h00, ys}, i_dev.ypos_r);
                chk("dev disp", disp_val | 32'h0008_0000, i_dev.disp_r);
            end
        end
        st0 = i_dev.stride_r;
        // Depth code outside the five legal values: nothing written
        run(2'b00, 5'd3, XR);
        rc(12'h004, 32'h0000_0008, "status bpp");
        chk("dev stride kept", st0, i_dev.stride_r);
        // Span of 65 at 8 bpp is not a multiple of 4 pixels
        run(2'b00, 5'd8, XR + 10'h001);
        rc(12'h004, 32'h0000_0004, "status align");
        chk("dev stride kept", st0, i_dev.stride_r);
        wr(12'h004, 32'h0000_000E);
        rc(12'h004, 32'h0000_0000, "status cleared");
        rc(12'h000, 32'h0000_0002, "ctrl");
        wrap_up();
    end
endmodule
